// ===== verilog/ccm_pkg.sv
// constants and types shared by the color correction matrix stage
package ccm_pkg;
    // sample widths, fixed at generation
    localparam int IN_W = 8;
    localparam int OUT_SAMPLE_W = 8;
    localparam int PIX_W = 3 * OUT_SAMPLE_W;
    localparam int PIN_W = 3 * IN_W;
    localparam int OFS_W = OUT_SAMPLE_W + 1;
    // coefficient format: signed, fraction bits below the point
    localparam int COEF_W = 18;
    localparam int COEF_FRAC = 15;
    localparam int EFF_W = COEF_W + 2;
    localparam int ACC_W = 32;
    localparam int TIM_W = 11;
    localparam int IRQ_W = 18;
    localparam int NCOEF = 9;
    // register bus
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    localparam logic [BUS_AW-1:0] REG_COEF0 = 8'h00;
    localparam logic [BUS_AW-1:0] REG_OFS0 = 8'h24;
    localparam logic [BUS_AW-1:0] REG_CTRL = 8'h30;
    localparam logic [BUS_AW-1:0] REG_STAT = 8'h34;
    localparam logic [BUS_AW-1:0] REG_TIME = 8'h38;
    localparam logic [BUS_AW-1:0] REG_IRQ = 8'h3C;
    localparam int CTRL_CMY_BIT = 0;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_BAYER_LSB = 1;
    localparam int TIME_ROWS_LSB = 16;
    // generation-time defaults
    localparam logic signed [COEF_W-1:0] COEF_ONE = 18'h0_8000;
    localparam logic signed [COEF_W-1:0] COEF_ZERO = 18'h0_0000;
    localparam logic signed [OFS_W-1:0] OFS_DEFAULT = 9'h000;
    localparam logic CMY_DEFAULT = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_DEFAULT = 18'h0_0001;
    localparam logic [TIM_W-1:0] INIT_TOTAL_COLS = 11'h716;
    localparam logic [TIM_W-1:0] INIT_TOTAL_ROWS = 11'h20D;
    // bayer phase: first two samples; the CMY reading is MY, YM, CY, YC
    typedef enum logic [1:0] {
        CCM_BP_RG = 2'h0,
        CCM_BP_GR = 2'h1,
        CCM_BP_BG = 2'h2,
        CCM_BP_GB = 2'h3
    } ccm_bayer_t;
    localparam ccm_bayer_t BAYER_DEFAULT = CCM_BP_BG;
    typedef logic signed [COEF_W-1:0] ccm_coef_t;
    typedef logic signed [EFF_W-1:0] ccm_eff_t;
endpackage

// ===== verilog/ccm_pix_if.sv
// valid/ready carrier for corrected pixel triples
`timescale 1ns/1ns
interface ccm_pix_if import ccm_pkg::*; ();
    logic valid;
    logic ready;
    logic [PIX_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== verilog/ccm_chan_mac.sv
// one output channel: dot product, offset and clip
`timescale 1ns/1ns
module ccm_chan_mac import ccm_pkg::*; (
    input wire ccm_eff_t rowCoef [3],
    input wire logic [PIN_W-1:0] pixIn,
    input wire logic signed [OFS_W-1:0] offset,
    output logic [OUT_SAMPLE_W-1:0] chanOut
);
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] scaled;
    localparam logic signed [ACC_W-1:0] MAXV = ACC_W'((1 << OUT_SAMPLE_W) - 1);

    // sum of products in fixed point, offset aligned to the fraction
    always_comb begin
        acc = ACC_W'(signed'(offset)) <<< COEF_FRAC;
        for (int i = 0; i < 3; i++) begin
            acc = acc + ACC_W'(rowCoef[i] * signed'({1'b0, pixIn[i*IN_W +: IN_W]}));
        end
        scaled = acc >>> COEF_FRAC;
        if (scaled < 0) begin
            chanOut = '0;
        end else if (scaled > MAXV) begin
            chanOut = MAXV[OUT_SAMPLE_W-1:0];
        end else begin
            chanOut = scaled[OUT_SAMPLE_W-1:0];
        end
    end
endmodule

// ===== verilog/ccm_skid_buf.sv
// two-entry buffer between the matrix and the gamma stage
`timescale 1ns/1ns
module ccm_skid_buf import ccm_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    ccm_pix_if.snk inSide,
    output logic outValid,
    input wire logic outReady,
    output logic [PIX_W-1:0] outData
);
    logic [PIX_W-1:0] ent_q [2];
    logic [1:0] full_q;
    logic ready_q;
    logic take;
    logic drain;

    assign take = ce && inSide.valid && ready_q;
    assign drain = ce && full_q[0] && outReady;
    assign inSide.ready = ready_q;
    assign outValid = full_q[0];
    assign outData = ent_q[0];

    // entry 0 faces the receiver, entry 1 catches a word during a stall
    always_ff @(posedge clk) begin
        if (rst) begin
            full_q <= '0;
            ready_q <= 1'b1;
            ent_q[0] <= '0;
            ent_q[1] <= '0;
        end else if (!full_q[0] || drain) begin
            full_q <= {1'b0, full_q[1] | take};
            ready_q <= 1'b1;
            if (full_q[1]) begin
                ent_q[0] <= ent_q[1];
            end else if (take) begin
                ent_q[0] <= inSide.data;
            end
        end else if (take) begin
            ent_q[1] <= inSide.data;
            full_q[1] <= 1'b1;
            ready_q <= 1'b0;
        end
    end

    a_buf_stall_hold: assert property (@(posedge clk) disable iff (rst)
        (full_q[0] && !outReady) |=> (full_q[0] && $stable(ent_q[0])))
        else $error("stalled word changed or lost");
endmodule

// ===== verilog/ccm_color_correction.sv
// color correction matrix stage with generation-time defaults
// What this block does
// - bayer phase and interrupt settings never change
// - initial timing replaced once real timing detected
// - phase picks one of four sample orderings
// - coefficients 18 bits, 15 fraction bits
// - defaults load coefficients at every reset
// - offsets signed, one bit wider than output
// - matrix accepts RGB or CMY triples
// - CMY mode multiplies matrix by conversion matrix
// - output width is 8, 10 or 12; this build fixes it at 8
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module ccm_color_correction import ccm_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [BUS_AW-1:0] regAddr,
    input wire logic [BUS_DW-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [BUS_DW-1:0] regRdData,
    input wire logic pixInValid,
    output logic pixInReady,
    input wire logic [PIN_W-1:0] pixIn,
    input wire logic hblankIn,
    input wire logic vblankIn,
    output logic pixOutValid,
    input wire logic pixOutReady,
    output logic [PIX_W-1:0] pixOut,
    output ccm_bayer_t bayerPhase,
    output logic [IRQ_W-1:0] irqControl,
    output logic timingLocked,
    output logic [TIM_W-1:0] totalCols,
    output logic [TIM_W-1:0] totalRows
);
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    ccm_coef_t coef_q [NCOEF];
    logic signed [OFS_W-1:0] ofs_q [3];
    logic cmyEn_q;
    ccm_eff_t eff_q [NCOEF];
    ccm_bayer_t bayer_q;
    logic [IRQ_W-1:0] irq_q;
    logic [BUS_DW-1:0] rdData_q;

    // effective coefficient; CMY folds in the -1/+1 conversion matrix
    function automatic ccm_eff_t effCoef(input ccm_coef_t k [NCOEF], input int r,
                                         input int c, input logic cmy);
        ccm_eff_t rowSum;
        ccm_eff_t own;
        rowSum = EFF_W'(k[r*3]) + EFF_W'(k[r*3+1]) + EFF_W'(k[r*3+2]);
        own = EFF_W'(k[r*3+c]);
        if (cmy) begin
            return rowSum - (own <<< 1);
        end
        return own;
    endfunction

    // word index of a register address, or all ones when misaligned
    function automatic logic [BUS_AW-1:0] wordOf(input logic [BUS_AW-1:0] a);
        if (a[1:0] != 2'h0) begin
            return '1;
        end
        return a >> 2;
    endfunction

    // coefficients: generation values at reset, bus writes otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCOEF; i++) begin
                coef_q[i] <= (i % 4 == 0) ? COEF_ONE : COEF_ZERO;
            end
        end else if (ce && regWr) begin
            for (int i = 0; i < NCOEF; i++) begin
                if (wordOf(regAddr) == wordOf(REG_COEF0) + BUS_AW'(i)) begin
                    coef_q[i] <= regWrData[COEF_W-1:0];
                end
            end
        end
    end

    // offsets, one bit wider than a sample and signed
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                ofs_q[i] <= OFS_DEFAULT;
            end
        end else if (ce && regWr) begin
            for (int i = 0; i < 3; i++) begin
                if (wordOf(regAddr) == wordOf(REG_OFS0) + BUS_AW'(i)) begin
                    ofs_q[i] <= regWrData[OFS_W-1:0];
                end
            end
        end
    end

    // control: input form select
    always_ff @(posedge clk) begin
        if (rst) begin
            cmyEn_q <= CMY_DEFAULT;
        end else if (ce && regWr && regAddr == REG_CTRL) begin
            cmyEn_q <= regWrData[CTRL_CMY_BIT];
        end
    end

    // effective matrix, rebuilt one cycle after any change
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCOEF; i++) begin
                eff_q[i] <= effCoef('{default: COEF_ZERO}, 0, 0, 1'b0);
            end
        end else if (ce) begin
            for (int i = 0; i < NCOEF; i++) begin
                eff_q[i] <= effCoef(coef_q, i / 3, i % 3, cmyEn_q);
            end
        end
    end

    // fixed-build settings: loaded at reset, no write path at all
    always_ff @(posedge clk) begin
        if (rst) begin
            bayer_q <= BAYER_DEFAULT;
            irq_q <= IRQ_DEFAULT;
        end
    end

    // ------------------------------------------------------------
    // timing detection
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CCM_TS_WAIT = 3'b001,
        CCM_TS_MEAS = 3'b010,
        CCM_TS_LOCK = 3'b100
    } ccm_tstate_t;
    ccm_tstate_t tState_q;
    logic hPrev_q;
    logic vPrev_q;
    logic hRise;
    logic vRise;
    logic [TIM_W-1:0] colCnt_q;
    logic [TIM_W-1:0] rowCnt_q;
    logic [TIM_W-1:0] lineCols_q;
    logic [TIM_W-1:0] totCols_q;
    logic [TIM_W-1:0] totRows_q;

    assign hRise = hblankIn && !hPrev_q;
    assign vRise = vblankIn && !vPrev_q;

    // edge history and per-line, per-frame counters
    always_ff @(posedge clk) begin
        if (rst) begin
            hPrev_q <= 1'b0;
            vPrev_q <= 1'b0;
            colCnt_q <= '0;
            rowCnt_q <= '0;
            lineCols_q <= '0;
        end else if (ce) begin
            hPrev_q <= hblankIn;
            vPrev_q <= vblankIn;
            if (hRise) begin
                lineCols_q <= colCnt_q;
                colCnt_q <= TIM_W'(1);
            end else begin
                colCnt_q <= colCnt_q + TIM_W'(1);
            end
            if (vRise) begin
                rowCnt_q <= '0;
            end else if (hRise) begin
                rowCnt_q <= rowCnt_q + TIM_W'(1);
            end
        end
    end

    // initial totals stand until one whole frame has been measured
    always_ff @(posedge clk) begin
        if (rst) begin
            tState_q <= CCM_TS_WAIT;
            totCols_q <= INIT_TOTAL_COLS;
            totRows_q <= INIT_TOTAL_ROWS;
        end else if (ce) begin
            unique case (tState_q)
                CCM_TS_WAIT: begin
                    if (vRise) begin
                        tState_q <= CCM_TS_MEAS;
                    end
                end
                CCM_TS_MEAS, CCM_TS_LOCK: begin
                    if (vRise) begin
                        tState_q <= CCM_TS_LOCK;
                        totCols_q <= lineCols_q;
                        totRows_q <= rowCnt_q;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // matrix datapath and output buffer
    // ------------------------------------------------------------
    ccm_pix_if pixLink ();
    logic [OUT_SAMPLE_W-1:0] chan [3];
    ccm_eff_t rowOf [3][3];

    // three identical channel engines, one per matrix row
    for (genvar r = 0; r < 3; r++) begin : gChan
        for (genvar c = 0; c < 3; c++) begin : gRow
            assign rowOf[r][c] = eff_q[r*3+c];
        end
        ccm_chan_mac uMac (
            .rowCoef(rowOf[r]),
            .pixIn(pixIn),
            .offset(ofs_q[r]),
            .chanOut(chan[r])
        );
        assign pixLink.data[r*OUT_SAMPLE_W +: OUT_SAMPLE_W] = chan[r];
    end

    assign pixLink.valid = pixInValid;

    ccm_skid_buf uBuf (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .inSide(pixLink),
        .outValid(pixOutValid),
        .outReady(pixOutReady),
        .outData(pixOut)
    );

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // read data stand for the one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk) begin
        if (rst || !regRd) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= '0;
            for (int i = 0; i < NCOEF; i++) begin
                if (wordOf(regAddr) == wordOf(REG_COEF0) + BUS_AW'(i)) begin
                    rdData_q[COEF_W-1:0] <= coef_q[i];
                end
            end
            for (int i = 0; i < 3; i++) begin
                if (wordOf(regAddr) == wordOf(REG_OFS0) + BUS_AW'(i)) begin
                    rdData_q[OFS_W-1:0] <= ofs_q[i];
                end
            end
            if (regAddr == REG_CTRL) begin
                rdData_q[CTRL_CMY_BIT] <= cmyEn_q;
            end
            if (regAddr == REG_STAT) begin
                rdData_q[STAT_LOCK_BIT] <= (tState_q == CCM_TS_LOCK);
                rdData_q[STAT_BAYER_LSB +: 2] <= bayer_q;
            end
            if (regAddr == REG_TIME) begin
                rdData_q[TIM_W-1:0] <= totCols_q;
                rdData_q[TIME_ROWS_LSB +: TIM_W] <= totRows_q;
            end
            if (regAddr == REG_IRQ) begin
                rdData_q[IRQ_W-1:0] <= irq_q;
            end
        end
    end

    // outputs straight from flops, except timingLocked, a compare on the state register
    assign regRdData = rdData_q;
    assign pixInReady = pixLink.ready;
    assign bayerPhase = bayer_q;
    assign irqControl = irq_q;
    assign timingLocked = (tState_q == CCM_TS_LOCK);
    assign totalCols = totCols_q;
    assign totalRows = totRows_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence sCtrlRead;
        regRd && regAddr == REG_CTRL;
    endsequence

    sequence sCmyIdentityRow0;
        ce && cmyEn_q && coef_q[0] == COEF_ONE && coef_q[1] == COEF_ZERO
            && coef_q[2] == COEF_ZERO;
    endsequence

    a_bayer_fixed: assert property (bayerPhase == BAYER_DEFAULT)
        else $error("bayer phase left its default");

    a_irq_fixed: assert property (irqControl == IRQ_DEFAULT)
        else $error("interrupt control left its default");

    a_timing_init: assert property (!timingLocked |->
        (totalCols == INIT_TOTAL_COLS && totalRows == INIT_TOTAL_ROWS))
        else $error("initial timing dropped before detection");

    a_timing_keep: assert property (timingLocked |=> timingLocked)
        else $error("detected timing lost without reset");

    a_coef_reload: assert property (@(posedge clk) $past(rst) |->
        (coef_q[0] == COEF_ONE && coef_q[1] == COEF_ZERO && coef_q[8] == COEF_ONE))
        else $error("coefficients not reloaded at reset");

    a_cmy_matrix: assert property (sCmyIdentityRow0 |=>
        (eff_q[0] == -EFF_W'(COEF_ONE) && eff_q[1] == EFF_W'(COEF_ONE)))
        else $error("cmy conversion not folded into matrix");

    a_ce_hold: assert property (!ce |=>
        ($stable(coef_q[0]) && $stable(eff_q[4]) && $stable(tState_q)))
        else $error("state moved while clock enable low");

    a_ctrl_read: assert property (sCtrlRead |=>
        (regRdData[CTRL_CMY_BIT] == $past(cmyEn_q)) ##1 (regRdData == '0 || $past(regRd)))
        else $error("control readback wrong or held too long");

    a_pass_ident: assert property ((pixInValid && eff_q[0] == EFF_W'(COEF_ONE)
        && eff_q[1] == '0 && eff_q[2] == '0 && ofs_q[0] == '0)
        |-> chan[0] == pixIn[IN_W-1:0])
        else $error("identity row did not pass the sample");
endmodule

// ===== tb/ccm_cfa_model.sv
// behavioural model of the upstream interpolation stage feeding the matrix
`timescale 1ns/1ns
module ccm_cfa_model import ccm_pkg::*; #(
    parameter int LINE_LEN = 20,
    parameter int FRAME_LINES = 4
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic timingRun,
    input wire logic pixInReady,
    output logic pixInValid,
    output logic [PIN_W-1:0] pixIn,
    output logic hblankIn,
    output logic vblankIn
);
    logic [7:0] colQ;
    logic [7:0] rowQ;

    // nothing offered at time zero
    initial begin
        pixInValid = 1'b0;
        pixIn = '0;
    end

    // raster counters; like the real stage they advance only while enabled
    always_ff @(posedge clk) begin
        if (!timingRun) begin
            colQ <= '0;
            rowQ <= '0;
        end else if (ce) begin
            colQ <= (colQ == 8'(LINE_LEN - 1)) ? 8'h00 : colQ + 8'h01;
            if (colQ == 8'(LINE_LEN - 1)) begin
                rowQ <= (rowQ == 8'(FRAME_LINES - 1)) ? 8'h00 : rowQ + 8'h01;
            end
        end
    end

    // blanking: line start, frame start a few cycles later so edges never coincide
    assign hblankIn = timingRun && (colQ < 8'h03);
    assign vblankIn = timingRun && (rowQ == 8'h00) && (colQ >= 8'h05) && (colQ < 8'h0a);

    // offer one triple, held until taken
    task automatic send(input logic [PIN_W-1:0] word, input int gap, output logic ok);
        int n;
        if (gap > 0) begin
            pixInValid <= 1'b0;
            pixIn <= ~pixIn; // released data never shows the last word
            repeat (gap) @(posedge clk);
        end
        pixInValid <= 1'b1;
        pixIn <= word;
        ok = 1'b0;
        for (n = 0; n < 500 && !ok; n++) begin
            @(posedge clk);
            ok = pixInReady && ce;
        end
    endtask

    // release the link after the last word
    task automatic idle();
        pixInValid <= 1'b0;
        pixIn <= ~pixIn;
    endtask
endmodule

// ===== tb/ccm_color_correction_tb_top.sv
// self-checking bench for the color correction matrix stage
`timescale 1ns/1ns
module ccm_color_correction_tb_top import ccm_pkg::*; ();
    localparam int LINE_LEN = 20;
    localparam int FRAME_LINES = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [BUS_AW-1:0] regAddr = '0;
    logic [BUS_DW-1:0] regWrData = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic pixOutReady = 1'b1;
    logic timingRun = 1'b0;
    logic [BUS_DW-1:0] regRdData;
    logic pixInValid, pixInReady, hblankIn, vblankIn, pixOutValid, timingLocked;
    logic [PIN_W-1:0] pixIn;
    logic [PIX_W-1:0] pixOut;
    ccm_bayer_t bayerPhase;
    logic [IRQ_W-1:0] irqControl;
    logic [TIM_W-1:0] totalCols, totalRows;
    logic [PIX_W-1:0] pixQ[$];
    logic [BUS_DW-1:0] rdQ[$];
    logic signed [COEF_W-1:0] kM[NCOEF];
    logic signed [OFS_W-1:0] oM[3];
    logic cmyM;
    logic rdPend = 1'b0;
    int fails = 0;
    int comparisons = 0;
    int stallMode = 0;

    ccm_color_correction ccm_color_correction_i (.clk, .rst, .ce, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .pixInValid, .pixInReady, .pixIn, .hblankIn, .vblankIn,
        .pixOutValid, .pixOutReady, .pixOut, .bayerPhase, .irqControl, .timingLocked,
        .totalCols, .totalRows);
    ccm_cfa_model #(.LINE_LEN(LINE_LEN), .FRAME_LINES(FRAME_LINES)) ccm_cfa_model_i (.clk,
        .ce, .timingRun, .pixInReady, .pixInValid, .pixIn, .hblankIn, .vblankIn);

    always #20 clk = ~clk;

    // ----------------------------------------
    // checking and reporting
    // ----------------------------------------
    task automatic chk_val(input logic [BUS_DW-1:0] got, input logic [BUS_DW-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pix(input logic [PIX_W-1:0] got, input logic [PIX_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: pixel got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic give_up(input string what);
        fails++;
        $display("ERROR at %0t: %s ran out, got %h expected %h", $time, what, pixQ.size(), 0);
        wrap_up();
    endtask

    // reference result: row dot triple, floor of the fraction, offset, clip
    function automatic logic [PIX_W-1:0] expect_pix(input logic [PIN_W-1:0] p);
        longint acc;
        longint kc;
        logic [PIX_W-1:0] r;
        for (int i = 0; i < 3; i++) begin
            acc = 0;
            for (int j = 0; j < 3; j++) begin
                kc = kM[3*i+j];
                if (cmyM) kc = kM[3*i] + kM[3*i+1] + kM[3*i+2] - 2 * kM[3*i+j];
                acc += kc * longint'(p[8*j +: 8]);
            end
            acc = (acc >>> COEF_FRAC) + oM[i];
            r[8*i +: 8] = (acc < 0) ? 8'h00 : (acc > 255) ? 8'hff : acc[7:0];
        end
        return r;
    endfunction

    // the monitor pairs each result with the oldest note
    always @(posedge clk) begin
        if (rdPend) chk_val(regRdData, rdQ.size() > 0 ? rdQ.pop_front() : 'x);
        rdPend = regRd;
        if (pixOutValid && pixOutReady && ce) begin
            chk_pix(pixOut, pixQ.size() > 0 ? pixQ.pop_front() : 'x);
        end
    end

    // receiver: always ready, random stall or full stall
    always @(posedge clk) pixOutReady <= (stallMode == 0) || (stallMode == 1 && 1'($urandom));

    initial begin
        repeat (60000) @(posedge clk);
        give_up("run");
    end

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    task automatic reg_wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
        regWr <= 1'b1;
        regRd <= 1'b0;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] e);
        rdQ.push_back(e);
        regRd <= 1'b1;
        regWr <= 1'b0;
        regAddr <= a;
        @(posedge clk);
    endtask

    task automatic bus_idle();
        regWr <= 1'b0;
        regRd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic push_pix(input logic [PIN_W-1:0] w, input int gap);
        logic ok;
        pixQ.push_back(expect_pix(w));
        ccm_cfa_model_i.send(w, gap, ok);
        if (!ok) give_up("pixel offer");
    endtask

    task automatic drain();
        ccm_cfa_model_i.idle();
        for (int n = 0; n < 2000 && pixQ.size() > 0; n++) @(posedge clk);
        if (pixQ.size() > 0) give_up("drain");
    endtask

    task automatic model_defaults();
        for (int i = 0; i < NCOEF; i++) kM[i] = (i % 4 == 0) ? COEF_ONE : COEF_ZERO;
        for (int i = 0; i < 3; i++) oM[i] = OFS_DEFAULT;
        cmyM = CMY_DEFAULT;
    endtask

    initial begin
        void'($urandom(32'h425592f0));
        model_defaults();
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        // defaults seen at the pins and in the registers
        @(negedge clk);
        chk_val(32'(bayerPhase), 32'(BAYER_DEFAULT));
        chk_val(32'(irqControl), 32'(IRQ_DEFAULT));
        chk_val({5'h0, totalRows, 5'h0, totalCols}, {5'h0, INIT_TOTAL_ROWS, 5'h0, INIT_TOTAL_COLS});
        @(posedge clk);
        for (int i = 0; i < NCOEF; i++) reg_rd(8'(REG_COEF0 + 4 * i), {14'h0, kM[i]});
        reg_rd(REG_OFS0, 32'h0);
        reg_rd(REG_STAT, {29'h0, BAYER_DEFAULT, 1'b0});
        reg_wr(REG_IRQ, 32'h0003_ffff);
        reg_rd(REG_IRQ, {14'h0, IRQ_DEFAULT});
        reg_rd(8'h40, 32'h0);
        bus_idle();
        $display("test defaults finished");
        // random matrix and offsets, RGB then CMY, receiver stalling
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < NCOEF; i++) begin
                kM[i] = 18'($urandom_range(32'h0_ffff)) - COEF_ONE;
                reg_wr(8'(REG_COEF0 + 4 * i), {14'h0, kM[i]});
            end
            for (int i = 0; i < 3; i++) begin
                oM[i] = 9'($urandom);
                reg_wr(8'(REG_OFS0 + 4 * i), {23'h0, oM[i]});
            end
            cmyM = m[0];
            reg_wr(REG_CTRL, 32'(m));
            reg_rd(8'(REG_COEF0 + 8'h20), {14'h0, kM[8]});
            reg_rd(8'(REG_OFS0 + 8'h08), {23'h0, oM[2]});
            bus_idle();
            @(negedge clk);
            stallMode = 1;
            @(posedge clk);
            repeat (30) push_pix(24'($urandom), $urandom_range(2));
            drain();
            $display("test matrix pass %0d finished", m);
        end
        // fill the buffer until it refuses, then drain
        @(negedge clk);
        stallMode = 2;
        @(posedge clk);
        repeat (2) push_pix(24'($urandom), 0);
        ccm_cfa_model_i.idle();
        @(negedge clk);
        chk_val(32'(pixInReady), 32'h0);
        stallMode = 0;
        drain();
        $display("test fill finished");
        // writes while disabled are dropped
        ce <= 1'b0;
        reg_wr(REG_COEF0, 32'h0000_1234);
        bus_idle();
        ce <= 1'b1;
        reg_rd(REG_COEF0, {14'h0, kM[0]});
        bus_idle();
        $display("test enable finished");
        // clear restores the defaults
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        model_defaults();
        repeat (2) @(posedge clk);
        reg_rd(REG_COEF0, {14'h0, COEF_ONE});
        reg_rd(REG_CTRL, 32'h0);
        bus_idle();
        repeat (4) push_pix(24'($urandom), 0);
        drain();
        // conversion folded into the default matrix
        cmyM = 1'b1;
        reg_wr(REG_CTRL, 32'h0000_0001);
        bus_idle();
        repeat (4) push_pix(24'($urandom), 0);
        drain();
        $display("test clear finished");
        // measured timing replaces the initial values
        timingRun <= 1'b1;
        for (int n = 0; n < 600 && timingLocked !== 1'b1; n++) @(negedge clk);
        chk_val(32'(timingLocked), 32'h1);
        chk_val({5'h0, totalRows, 5'h0, totalCols}, (32'(FRAME_LINES) << 16) | 32'(LINE_LEN));
        @(posedge clk);
        reg_rd(REG_TIME, (32'(FRAME_LINES) << 16) | 32'(LINE_LEN));
        reg_rd(REG_STAT, {29'h0, BAYER_DEFAULT, 1'b1});
        bus_idle();
        chk_val(32'(bayerPhase), 32'(BAYER_DEFAULT));
        $display("test timing finished");
        repeat (3) @(posedge clk);
        wrap_up();
    end
endmodule
